// File: dsrc_defs.svh
// constants for the drive stop, trip and restart control block
`ifndef DSRC_DEFS_SVH
`define DSRC_DEFS_SVH
// input function codes
`define DSRC_FN_FWD 5'h00
`define DSRC_FN_REV 5'h01
`define DSRC_FN_COAST 5'h0B
`define DSRC_FN_EXTFLT 5'h0C
`define DSRC_FN_GUARD 5'h0D
`define DSRC_FN_CLEAR 5'h12
// register byte offsets
`define DSRC_OFS_CTRL 8'h00
`define DSRC_OFS_DELAY 8'h04
`define DSRC_OFS_ASSIGN 8'h08
`define DSRC_OFS_STATUS 8'h0C
`define DSRC_OFS_HIST 8'h10
// control fields
`define DSRC_CTRL_POL_LSB 0
`define DSRC_CTRL_SPEED_BIT 8
`define DSRC_CTRL_KEYRST_BIT 9
// reset values
`define DSRC_CTRL_RST 32'h0000_0000
`define DSRC_DELAY_RST 32'h0000_0000
// assignment reset: 1:fwd 2:rev 3:coast 4:ext 5:guard 6:clear 7:unused
`define DSRC_ASSIGN_RST 35'h7_E4D6_2C20
// timing
`define DSRC_CLK_HZ 50000000
`define DSRC_TICK_US 100
// power-up window must outlast the pin synchroniser
`define DSRC_PWRUP_CYC 3'h4
`define DSRC_TICK_CYC ((`DSRC_CLK_HZ / 1000000) * `DSRC_TICK_US)
`endif

// File: dsrc_pkg.sv
// types for the drive stop, trip and restart control block
`default_nettype none
package dsrc_pkg;
   // drive state
   typedef enum logic [2:0] {
      ST_STOP, ST_RUN, ST_COAST, ST_WAIT, ST_TRIP, ST_GUARD, ST_CLEAR
   } dsrc_state_t;
   // trip cause codes
   typedef enum logic [1:0] {
      TC_NONE, TC_EXT, TC_GUARD
   } dsrc_trip_t;
endpackage : dsrc_pkg
`default_nettype wire

// File: dsrc_in_cond.sv
// one input terminal: two-flop synchroniser, polarity, edge detect
`default_nettype none
module dsrc_in_cond (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic pinIn,
   input wire logic invert,
   output logic level,
   output logic rise
);
   // first flop is read by the second flop only
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   logic level_next;

   // polarity applied after the synchroniser
   always_comb begin
      level_next = sync_reg ^ invert;
   end

   // synchroniser and edge memory
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pinIn;
         sync_reg <= meta_reg;
         prev_reg <= level_next;
      end
   end

   assign level = level_next;
   assign rise = level_next & ~prev_reg;
endmodule : dsrc_in_cond
`default_nettype wire

// File: dsrc_ctrl.sv
// drive stop, trip and restart control with an AXI4-Lite register slave
`default_nettype none
`include "dsrc_defs.svh"
module dsrc_ctrl #(
   parameter int NUM_IN = 7,
   parameter int DELAY_W = 16
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [NUM_IN-1:0] terminalIn,
   output logic driveEnable,
   output logic driveReverse,
   output logic matchSpeed,
   output logic alarmOut,
   output logic [1:0] tripCode,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // =========================================================
   // elaboration checks
   if (NUM_IN != 7) $error("seven terminals are required");
   if (DELAY_W < 1 || DELAY_W > 32) $error("bad delay width");

   // =========================================================
   // input conditioning
   logic [6:0] polReg; // per-terminal inversion
   logic [34:0] assignReg; // five-bit function code per terminal
   logic [NUM_IN-1:0] lvl;
   logic [NUM_IN-1:0] rse;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_in
         // synchronise and correct polarity before edges
         dsrc_in_cond u_cond (
            .clock(clock),
            .sys_rst(sys_rst),
            .pinIn(terminalIn[gi]),
            .invert(polReg[gi]),
            .level(lvl[gi]),
            .rise(rse[gi])
         );
      end
   endgenerate

   // function view: OR of every terminal assigned to each function
   logic fwd, rev, coast, extLvl, extRise, guardOn, clrLvl, runRise;
   logic fwdRise, revRise;
   always_comb begin
      fwd = 1'b0; rev = 1'b0; coast = 1'b0; extLvl = 1'b0;
      extRise = 1'b0; guardOn = 1'b0; clrLvl = 1'b0;
      fwdRise = 1'b0; revRise = 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
         case (assignReg[i*5 +: 5])
            `DSRC_FN_FWD: begin fwd |= lvl[i]; fwdRise |= rse[i]; end
            `DSRC_FN_REV: begin rev |= lvl[i]; revRise |= rse[i]; end
            `DSRC_FN_COAST: coast |= lvl[i];
            `DSRC_FN_EXTFLT: begin
               extLvl |= lvl[i];
               extRise |= rse[i]; // only off-to-on counts
            end
            `DSRC_FN_GUARD: guardOn |= lvl[i];
            // clear terminal is normally open only: ignore inversion
            `DSRC_FN_CLEAR: clrLvl |= lvl[i] ^ polReg[i];
            default: ;
         endcase
      end
      runRise = fwdRise | revRise;
   end

   // both directions at once is a stop request
   logic runCmd;
   assign runCmd = fwd ^ rev;

   // =========================================================
   // tick divider for the resume delay
   localparam int TICK = `DSRC_TICK_CYC;
   logic [12:0] div_reg, div_next;
   logic tick;
   always_comb begin
      tick = (div_reg == 13'(TICK - 1));
      div_next = tick ? 13'h0000 : div_reg + 13'h0001;
   end

   // =========================================================
   // drive state machine
   dsrc_pkg::dsrc_state_t st_reg, st_next;
   dsrc_pkg::dsrc_trip_t cause_reg, cause_next;
   logic [DELAY_W-1:0] dly_reg, dly_next, delaySet;
   // power-up window: open a few cycles so synced pins are seen in it
   logic pwr_reg, pwr_next;
   logic [2:0] pwrCnt_reg, pwrCnt_next; // cycles since release
   logic [1:0] hist_reg, hist_next;
   logic keyRst; // software keypad reset pulse
   logic speedSel;
   logic rsFall;
   logic clr_prev_reg;
   assign rsFall = clr_prev_reg & ~clrLvl;

   always_comb begin
      st_next = st_reg;
      cause_next = cause_reg;
      dly_next = dly_reg;
      pwr_next = pwr_reg && (pwrCnt_reg != `DSRC_PWRUP_CYC);
      pwrCnt_next = pwr_reg ? pwrCnt_reg + 3'h1 : pwrCnt_reg;
      hist_next = hist_reg;
      if (clrLvl) begin
         // reset held on: output off, trips cleared
         st_next = dsrc_pkg::ST_CLEAR;
         cause_next = dsrc_pkg::TC_NONE;
      end else begin
         case (st_reg)
            dsrc_pkg::ST_CLEAR: begin
               // reset released: history wiped
               hist_next = 2'b00;
               if (runCmd && guardOn && cause_reg == dsrc_pkg::TC_NONE
                   && !rsFall)
                  st_next = dsrc_pkg::ST_GUARD;
               else if (runCmd)
                  st_next = dsrc_pkg::ST_RUN;
               else
                  st_next = dsrc_pkg::ST_STOP;
            end
            dsrc_pkg::ST_STOP: begin
               if (pwr_reg && runCmd && guardOn) begin
                  st_next = dsrc_pkg::ST_GUARD;
                  cause_next = dsrc_pkg::TC_GUARD;
               end else if (runCmd && !coast && (pwr_reg || !guardOn
                            || runRise))
                  st_next = dsrc_pkg::ST_RUN;
            end
            dsrc_pkg::ST_RUN: begin
               if (coast) st_next = dsrc_pkg::ST_COAST;
               else if (!runCmd) st_next = dsrc_pkg::ST_STOP;
            end
            dsrc_pkg::ST_COAST: begin
               if (!coast) begin
                  if (!runCmd) st_next = dsrc_pkg::ST_STOP;
                  else if (delaySet == '0)
                     st_next = dsrc_pkg::ST_RUN;
                  else begin
                     st_next = dsrc_pkg::ST_WAIT;
                     dly_next = delaySet;
                  end
               end
            end
            dsrc_pkg::ST_WAIT: begin
               if (coast) st_next = dsrc_pkg::ST_COAST;
               else if (!runCmd) st_next = dsrc_pkg::ST_STOP;
               else if (tick) begin
                  if (dly_reg <= DELAY_W'(1))
                     st_next = dsrc_pkg::ST_RUN;
                  dly_next = dly_reg - DELAY_W'(1);
               end
            end
            dsrc_pkg::ST_TRIP: begin
               // held until reset; fault going off changes nothing
               if (keyRst) begin
                  st_next = dsrc_pkg::ST_STOP;
                  cause_next = dsrc_pkg::TC_NONE;
               end
            end
            dsrc_pkg::ST_GUARD: begin
               if (!runCmd || keyRst) begin
                  st_next = dsrc_pkg::ST_STOP;
                  cause_next = dsrc_pkg::TC_NONE;
               end
            end
            default: st_next = dsrc_pkg::ST_STOP;
         endcase
         // external fault wins from any non-reset state
         if (extRise) begin
            st_next = dsrc_pkg::ST_TRIP;
            cause_next = dsrc_pkg::TC_EXT;
            hist_next[0] = 1'b1;
         end
         if (cause_next == dsrc_pkg::TC_GUARD) hist_next[1] = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= dsrc_pkg::ST_STOP;
         cause_reg <= dsrc_pkg::TC_NONE;
         dly_reg <= '0;
         pwr_reg <= 1'b1;
         pwrCnt_reg <= 3'h0;
         hist_reg <= 2'b00;
         div_reg <= 13'h0000;
         clr_prev_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cause_reg <= cause_next;
         dly_reg <= dly_next;
         pwr_reg <= pwr_next;
         pwrCnt_reg <= pwrCnt_next;
         hist_reg <= hist_next;
         div_reg <= div_next;
         clr_prev_reg <= clrLvl;
      end
   end

   // outputs: drive off in every state but run
   always_comb begin
      driveEnable = (st_reg == dsrc_pkg::ST_RUN);
      driveReverse = rev & ~fwd;
      alarmOut = (cause_reg != dsrc_pkg::TC_NONE);
      tripCode = cause_reg;
      matchSpeed = speedSel;
   end

   // =========================================================
   // AXI4-Lite register slave
   logic [31:0] ctrl_reg, ctrl_next, dlyr_reg, dlyr_next;
   logic [34:0] asg_reg, asg_next;
   logic [7:0] wa_reg, wa_next;
   logic awh_reg, awh_next, wh_reg, wh_next, bv_reg, bv_next;
   logic [31:0] wd_reg, wd_next;
   logic rv_reg, rv_next;
   logic [31:0] rd_reg, rd_next;
   logic [1:0] rr_reg, rr_next, br_reg, br_next;
   logic doWr, wOk;

   assign polReg = ctrl_reg[`DSRC_CTRL_POL_LSB +: 7];
   assign speedSel = ctrl_reg[`DSRC_CTRL_SPEED_BIT];
   assign assignReg = asg_reg;
   assign delaySet = dlyr_reg[DELAY_W-1:0];
   // self-clearing keypad reset, only acts in the trip and guard states
   assign keyRst = ctrl_reg[`DSRC_CTRL_KEYRST_BIT];

   always_comb begin
      awh_next = awh_reg; wh_next = wh_reg; bv_next = bv_reg;
      wa_next = wa_reg; wd_next = wd_reg; br_next = br_reg;
      ctrl_next = ctrl_reg;
      ctrl_next[`DSRC_CTRL_KEYRST_BIT] = 1'b0;
      dlyr_next = dlyr_reg; asg_next = asg_reg;
      rv_next = rv_reg; rd_next = rd_reg; rr_next = rr_reg;
      wOk = 1'b1;
      // capture address and data in either order
      if (s_axi_awvalid && !awh_reg) begin
         awh_next = 1'b1; wa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wh_reg) begin
         wh_next = 1'b1; wd_next = s_axi_wdata;
      end
      doWr = awh_reg && wh_reg && !bv_reg;
      if (doWr) begin
         awh_next = 1'b0; wh_next = 1'b0; bv_next = 1'b1;
         case (wa_reg)
            `DSRC_OFS_CTRL: ctrl_next = wd_reg & 32'h0000_03FF;
            `DSRC_OFS_DELAY: dlyr_next = wd_reg;
            `DSRC_OFS_ASSIGN: asg_next[31:0] = wd_reg;
            default: wOk = 1'b0;
         endcase
         br_next = wOk ? 2'b00 : 2'b10;
      end
      if (bv_reg && s_axi_bready) bv_next = 1'b0;
      // reads answer one cycle after the address is taken
      if (s_axi_arvalid && !rv_reg) begin
         rv_next = 1'b1; rr_next = 2'b00;
         case (s_axi_araddr)
            `DSRC_OFS_CTRL: rd_next = ctrl_reg;
            `DSRC_OFS_DELAY: rd_next = dlyr_reg;
            `DSRC_OFS_ASSIGN: rd_next = asg_reg[31:0];
            `DSRC_OFS_STATUS: rd_next = {24'h000000, 1'b0, st_reg,
                                         cause_reg, driveEnable, alarmOut};
            `DSRC_OFS_HIST: rd_next = {29'h00000000, asg_reg[34:32]} <<
                               8 | {30'h00000000, hist_reg};
            default: begin rd_next = 32'h0000_0000; rr_next = 2'b10; end
         endcase
      end else if (rv_reg && s_axi_rready) rv_next = 1'b0;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         awh_reg <= 1'b0; wh_reg <= 1'b0; bv_reg <= 1'b0;
         wa_reg <= 8'h00; wd_reg <= 32'h0000_0000; br_reg <= 2'b00;
         ctrl_reg <= `DSRC_CTRL_RST;
         dlyr_reg <= `DSRC_DELAY_RST;
         asg_reg <= `DSRC_ASSIGN_RST;
         rv_reg <= 1'b0; rd_reg <= 32'h0000_0000; rr_reg <= 2'b00;
      end else begin
         awh_reg <= awh_next; wh_reg <= wh_next; bv_reg <= bv_next;
         wa_reg <= wa_next; wd_reg <= wd_next; br_reg <= br_next;
         ctrl_reg <= ctrl_next; dlyr_reg <= dlyr_next; asg_reg <= asg_next;
         rv_reg <= rv_next; rd_reg <= rd_next; rr_reg <= rr_next;
      end
   end

   assign s_axi_awready = ~awh_reg;
   assign s_axi_wready = ~wh_reg;
   assign s_axi_bvalid = bv_reg;
   assign s_axi_bresp = br_reg;
   assign s_axi_arready = ~rv_reg;
   assign s_axi_rvalid = rv_reg;
   assign s_axi_rdata = rd_reg;
   assign s_axi_rresp = rr_reg;
endmodule : dsrc_ctrl
`default_nettype wire

// File: dsrc_ctrl_sva.sv
// checker for the drive stop, trip and restart control block
`default_nettype none
module dsrc_ctrl_sva #(
   parameter int NUM_IN = 7
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [NUM_IN-1:0] terminalIn,
   input wire logic driveEnable,
   input wire logic driveReverse,
   input wire logic matchSpeed,
   input wire logic alarmOut,
   input wire logic [1:0] tripCode,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready
);
   // ==========================================================
   // helper: mirror of polarity and speed select, quiet counter
   logic [NUM_IN-1:0] pol_reg; // polarity as last written
   logic spd_reg; // speed select as last written
   logic [3:0] quiet_reg; // cycles with no clear source active
   logic ctrlWr; // control word taken this edge
   logic [NUM_IN-1:0] eff; // terminals after polarity
   assign ctrlWr = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr == 8'h00;
   assign eff = terminalIn ^ pol_reg;
   // keypad writes and the clear pin both restart the quiet count
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pol_reg <= '0;
         spd_reg <= 1'h0;
         quiet_reg <= 4'h0;
      end else begin
         if (ctrlWr) begin
            pol_reg <= s_axi_wdata[NUM_IN-1:0];
            spd_reg <= s_axi_wdata[8];
         end
         if (ctrlWr || terminalIn[5]) quiet_reg <= 4'h0;
         else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
      end
   end
   // ==========================================================
   // assertions; windows allow for the two-flop synchroniser
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   AST_COAST_OFF: assert property (eff[2] [*6] |-> !driveEnable)
      else $error("drive on while coast held");
   AST_NO_RUN: assert property (!eff[0] && !eff[1] [*6] |-> !driveEnable)
      else $error("drive on with no run command");
   AST_SPEED: assert property (ctrlWr |=> ##2 matchSpeed == spd_reg)
      else $error("speed select not applied");
   AST_EXT_TRIP: assert property ($rose(eff[3]) && !alarmOut
      && !terminalIn[5] |-> ##[1:6] alarmOut && tripCode == 2'h1)
      else $error("external fault did not trip");
   AST_TRIP_HOLD: assert property (tripCode == 2'h1 && quiet_reg > 4'h7
      |=> tripCode == 2'h1)
      else $error("external trip dropped without clear");
   AST_ALARM_COAST: assert property (alarmOut |-> !driveEnable)
      else $error("drive on while alarm set");
   AST_BOTH_STOP: assert property (eff[0] && eff[1] [*6] |-> !driveEnable)
      else $error("drive on with both directions");
   AST_REVERSE: assert property (eff[1] && !eff[0] [*6] |-> driveReverse)
      else $error("reverse direction not shown");
   AST_CLEAR_HELD: assert property (terminalIn[5] [*5]
      |-> !driveEnable && !alarmOut)
      else $error("drive or alarm while clear held");
endmodule : dsrc_ctrl_sva
`default_nettype wire

// File: dsrc_contacts.sv
// model of the external contacts wired to the drive terminals
`default_nettype none
module dsrc_contacts (
   input wire logic runFwd,
   input wire logic runRev,
   input wire logic coastCmd,
   input wire logic faultCmd,
   input wire logic guardCmd,
   input wire logic clearCmd,
   input wire logic [6:0] invMask,
   output logic [6:0] pins
);
   // a normally closed contact reads as the inverse of its command
   assign pins[4:0] = {guardCmd, faultCmd, coastCmd, runRev, runFwd}
      ^ invMask[4:0];
   // clear contact is normally open only, so no inversion
   assign pins[5] = clearCmd;
   // spare terminal left open: it rests at its inactive level
   assign pins[6] = invMask[6];
endmodule : dsrc_contacts
`default_nettype wire

// File: testbench.sv
// self-checking bench for the drive stop, trip and restart control block
`default_nettype none
`include "dsrc_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // stimulus and observed signals
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   logic fwd = 1'h1, rev = 1'h0, coast = 1'h0; // run active at power-up
   logic external_fault_input = 1'h0, guard = 1'h0, clr = 1'h0;
   logic [6:0] invMask = 7'h00;
   logic [6:0] pins;
   logic drv, drvRev, spd, alm;
   logic [1:0] code, bresp, rresp, rsp;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [34:0] asgRst = `DSRC_ASSIGN_RST;
   int errors = 0, checked = 0;
   always #10 clock = ~clock;
   dsrc_contacts contacts (.runFwd(fwd), .runRev(rev), .coastCmd(coast),
      .faultCmd(external_fault_input), .guardCmd(guard), .clearCmd(clr), .invMask(invMask),
      .pins(pins));
   dsrc_ctrl #(.NUM_IN(7), .DELAY_W(16)) DUT (.clock(clock),
      .sys_rst(sys_rst), .terminalIn(pins), .driveEnable(drv),
      .driveReverse(drvRev), .matchSpeed(spd), .alarmOut(alm),
      .tripCode(code), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   // ==========================================================
   // verdict, compares and bus tasks
   task automatic test_done();
      if (errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic cmp(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // drive, alarm and trip cause checked as one word
   task automatic chk(input string what, input logic d, input logic a,
         input logic [1:0] c);
      cmp(what, {28'h0, d, a, c}, {28'h0, drv, alm, code});
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
   endtask : settle
   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clock);
         t++;
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1 && t < 50);
      rsp = bresp;
      bready <= 1'h0;
      if (t >= 50) errors++;
   endtask : wr
   task automatic rdReg(input logic [7:0] a);
      int t;
      t = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clock);
         t++;
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1 && t < 50);
      rd = rdata;
      rsp = rresp;
      rready <= 1'h0;
      if (t >= 50) errors++;
   endtask : rdReg
   // reset doubles as a power cycle
   task automatic powerUp();
      sys_rst <= 1'h1;
      settle(3);
      sys_rst <= 1'h0;
      settle(10);
   endtask : powerUp
   // ==========================================================
   // main sequence
   initial begin
      powerUp();
      chk("powerup run", 1'h1, 1'h0, 2'h0);
      rdReg(`DSRC_OFS_ASSIGN);
      cmp("assign reset", asgRst[31:0], rd);
      rdReg(`DSRC_OFS_DELAY);
      cmp("delay reset", `DSRC_DELAY_RST, rd);
      rdReg(8'h20);
      cmp("unmapped resp", 32'h2, {30'h0, rsp});
      wr(`DSRC_OFS_STATUS, 32'h1);
      cmp("status write resp", 32'h2, {30'h0, rsp});
      rev <= 1'h1;
      settle(8);
      chk("both run", 1'h0, 1'h0, 2'h0);
      fwd <= 1'h0;
      settle(8);
      cmp("reverse", {31'h0, 1'h1}, {31'h0, drvRev});
      fwd <= 1'h1;
      rev <= 1'h0;
      coast <= 1'h1;
      settle(8);
      chk("coast held", 1'h0, 1'h0, 2'h0);
      coast <= 1'h0;
      settle(8);
      chk("coast release", 1'h1, 1'h0, 2'h0);
      coast <= 1'h1;
      fwd <= 1'h0;
      settle(8);
      coast <= 1'h0;
      settle(8);
      chk("release no run", 1'h0, 1'h0, 2'h0);
      // coast terminal made normally closed, speed match chosen
      wr(`DSRC_OFS_CTRL, 32'h0000_0104);
      invMask <= 7'h04;
      fwd <= 1'h1;
      settle(8);
      cmp("match speed", 32'h1, {31'h0, spd});
      chk("nc coast idle", 1'h1, 1'h0, 2'h0);
      coast <= 1'h1;
      settle(8);
      chk("nc coast held", 1'h0, 1'h0, 2'h0);
      coast <= 1'h0;
      wr(`DSRC_OFS_CTRL, 32'h0);
      invMask <= 7'h00;
      wr(`DSRC_OFS_DELAY, 32'h2);
      coast <= 1'h1;
      settle(8);
      cmp("zero speed", 32'h0, {31'h0, spd});
      coast <= 1'h0;
      settle(4900);
      chk("delay wait", 1'h0, 1'h0, 2'h0);
      settle(5300);
      chk("delay done", 1'h1, 1'h0, 2'h0);
      wr(`DSRC_OFS_DELAY, 32'h0);
      external_fault_input <= 1'h1;
      settle(8);
      chk("ext trip", 1'h0, 1'h1, 2'h1);
      external_fault_input <= 1'h0;
      settle(8);
      chk("ext off", 1'h0, 1'h1, 2'h1);
      rdReg(`DSRC_OFS_STATUS);
      cmp("status", {25'h0, dsrc_pkg::ST_TRIP, dsrc_pkg::TC_EXT, 2'h1},
         rd & 32'h7F);
      rdReg(`DSRC_OFS_HIST);
      cmp("hist set", 32'h1, rd & 32'h3);
      clr <= 1'h1;
      settle(8);
      chk("clear held", 1'h0, 1'h0, 2'h0);
      clr <= 1'h0;
      settle(8);
      chk("clear release", 1'h1, 1'h0, 2'h0);
      rdReg(`DSRC_OFS_HIST);
      cmp("hist clear", 32'h0, rd & 32'h3);
      external_fault_input <= 1'h1;
      settle(8);
      external_fault_input <= 1'h0;
      wr(`DSRC_OFS_CTRL, 32'h200);
      settle(8);
      cmp("keypad clear", 32'h0, {31'h0, alm});
      guard <= 1'h1;
      powerUp(); // run held through power-up trips the guard
      chk("guard trip", 1'h0, 1'h1, 2'h2);
      fwd <= 1'h0;
      settle(8);
      chk("guard run off", 1'h0, 1'h0, 2'h0);
      fwd <= 1'h1;
      settle(8);
      chk("guard new run", 1'h1, 1'h0, 2'h0);
      powerUp();
      clr <= 1'h1;
      settle(8);
      clr <= 1'h0;
      settle(8);
      chk("guard pin clear", 1'h1, 1'h0, 2'h0);
      external_fault_input <= 1'h1;
      settle(8);
      external_fault_input <= 1'h0;
      wr(`DSRC_OFS_CTRL, 32'h200);
      settle(8);
      chk("guard no restart", 1'h0, 1'h0, 2'h0);
      fwd <= 1'h0;
      settle(8);
      fwd <= 1'h1;
      settle(8);
      chk("guard run edge", 1'h1, 1'h0, 2'h0);
      test_done();
   end
   // watchdog: the sequence needs about 10500 cycles
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      test_done();
   end
endmodule : testbench
bind dsrc_ctrl dsrc_ctrl_sva #(.NUM_IN(NUM_IN)) chk_i (.clock(clock),
   .sys_rst(sys_rst), .terminalIn(terminalIn), .driveEnable(driveEnable),
   .driveReverse(driveReverse), .matchSpeed(matchSpeed),
   .alarmOut(alarmOut), .tripCode(tripCode), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready));
`default_nettype wire
